// ==== dv/alarm_supervisor_protect_output_tb.sv ====
// Self-checking bench of the alarm supervisor.
// Assumes a short tick parameter so that delays take few cycles.
`timescale 1ns/1ps
`default_nettype none
module alarm_supervisor_protect_output_tb;
    logic clk_sys, rst, prm_we, checksum_done, checksum_ok, transient, short_detect;
    logic exc_overcurrent, output_polarity_flag, use_param_uspd, protective_alarm_output, allc, ldef, stp, exo, blk;
    logic clim, vfr, exov, sel60, sev, srt, nvw, led;
    logic [7:0] prm_addr;
    logic [15:0] prm_wdata, vout_meas, run_freq, freq_meas, prm_rdata_r, status_word_r;
    logic [15:0] exc_observer, trim;
    int fails = 0;
    int checks_done = 0;
    asp_ctrl_model ctrl (.clk_sys(clk_sys), .excitation_off_r(exo), .run_freq(run_freq),
        .freq_meas(freq_meas));
    asp_top #(.TICK_CYCLES(10)) dut (.clk_sys(clk_sys), .rst(rst), .prm_we(prm_we),
        .prm_addr(prm_addr), .prm_wdata(prm_wdata), .prm_rdata_r(prm_rdata_r),
        .checksum_done(checksum_done), .checksum_ok(checksum_ok), .transient(transient),
        .freq_meas(freq_meas), .vout_meas(vout_meas), .vout_nominal(16'h03E8),
        .ov_threshold(16'h044C), .exc_overvolt(exov), .short_detect(short_detect),
        .exc_overcurrent(exc_overcurrent), .exc_observer(exc_observer), .sel_60hz_pin(sel60),
        .freq_sel_sw_mode(1'b0), .freq_sel_sw_60(1'b0), .use_param_uspd(use_param_uspd),
        .trimmer_uspd_thr(trim), .output_polarity_flag(output_polarity_flag),
        .protective_alarm_output_r(protective_alarm_output), .led_r(led), .status_word_r(status_word_r),
        .all_clear_indicator_r(allc), .load_defaults_r(ldef), .nvm_write_r(nvw),
        .saved_event_record_r(sev), .saved_run_time_r(srt), .regulator_blocked_r(blk),
        .stop_indicator_r(stp), .excitation_off_r(exo), .current_limit_r(clim),
        .vf_ramp_active_r(vfr));
    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        cyc(1);
        prm_we = 1'b1;
        prm_addr = a;
        prm_wdata = d;
        cyc(1);
        prm_we = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] exp);
        cyc(1);
        prm_addr = a;
        cyc(2);
        chk("prm_rdata_r", exp, prm_rdata_r);
    endtask
    task automatic alarm(input int k, input logic on);
        if (k == 0) begin
            vout_meas = on ? 16'h04B0 : 16'h03E8;
        end else begin
            exc_observer = on ? 16'hF001 : 16'h1000;
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // ----------------------------------------------------------------
    // Clock, watchdog, tests
    // ----------------------------------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    initial begin
        #100us;
        fails++;
        tally_and_finish();
    end
    initial begin
        {rst, prm_we, checksum_done, checksum_ok, transient, short_detect} = 6'b100000;
        {exc_overcurrent, output_polarity_flag, use_param_uspd} = 3'b001;
        {prm_addr, prm_wdata, trim, run_freq} = {8'h00, 16'h0000, 16'h0000, 16'h01F4};
        vout_meas = 16'h03E8;
        {exov, sel60} = 2'b00;
        exc_observer = 16'h1000;
        cyc(5);
        rst = 1'b0;
        chk("status_word_r", 16'h0800, status_word_r);
        rd(asp_pkg::ADDR_STATUS, 16'h0800);
        rd(asp_pkg::ADDR_PROT_CFG, 16'h0000);
        rd(8'h77, 16'h0000);
        checksum_ok = 1'b1;
        checksum_done = 1'b1;
        cyc(1);
        checksum_done = 1'b0;
        output_polarity_flag = 1'b1;
        cyc(4);
        chk("apo", 16'h0001, 16'(protective_alarm_output));
        for (int k = 0; k < 2; k++) begin
            wr(asp_pkg::ADDR_PROT_CFG, (k == 0) ? 16'h0002 : 16'h0080);
            alarm(k, 1'b1);
            cyc(4);
            chk("status_word_r", (k == 0) ? 16'h0002 : 16'h0080, status_word_r);
            chk("apo", 16'h0000, 16'(protective_alarm_output));
            alarm(k, 1'b0);
            cyc(4);
            chk("apo", 16'h0001, 16'(protective_alarm_output));
        end
        wr(asp_pkg::ADDR_PROT_CFG, 16'h0040);
        alarm(0, 1'b1);
        cyc(4);
        chk("apo", 16'h0001, 16'(protective_alarm_output));
        chk("allc", 16'h0000, 16'(allc));
        wr(asp_pkg::ADDR_PROT_CFG, 16'h0002);
        transient = 1'b1;
        cyc(4);
        chk("apo", 16'h0001, 16'(protective_alarm_output));
        output_polarity_flag = 1'b0;
        wr(asp_pkg::ADDR_PROT_CFG, 16'h1002);
        transient = 1'b0;
        cyc(90);
        chk("apo", 16'h0000, 16'(protective_alarm_output));
        cyc(25);
        chk("apo", 16'h0001, 16'(protective_alarm_output));
        alarm(0, 1'b0);
        $display("test protective output done");
        exc_overcurrent = 1'b1;
        use_param_uspd = 1'b0;
        trim = 16'h0258;
        cyc(6);
        chk("clim", 16'h0001, 16'(clim));
        chk("vfr", 16'h0001, 16'(vfr));
        {exc_overcurrent, trim} = {1'b0, 16'h01A4};
        cyc(4);
        chk("vfr", 16'h0000, 16'(vfr));
        sel60 = 1'b1;
        cyc(5);
        chk("vfr", 16'h0001, 16'(vfr));
        {sel60, trim} = {1'b0, 16'h0000};
        {exov, vout_meas} = {1'b1, 16'h0380};
        cyc(3);
        chk("status_word_r", 16'h0800, status_word_r);
        exov = 1'b0;
        cyc(1);
        chk("sev", 16'h0001, 16'(sev));
        chk("srt", 16'h0001, 16'(srt));
        cyc(2);
        chk("status_word_r", 16'h0004, status_word_r);
        vout_meas = 16'h03E8;
        run_freq = 16'h0064;
        cyc(3);
        chk("exo", 16'h0001, 16'(exo));
        cyc(4);
        chk("exo", 16'h0000, 16'(exo));
        run_freq = 16'h01F4;
        $display("test speed and voltage done");
        short_detect = 1'b1;
        cyc(40);
        chk("stp", 16'h0000, 16'(stp));
        chk("led", 16'h0001, 16'(led));
        wr(asp_pkg::ADDR_SC_TIME, 16'h0002);
        for (int i = 0; i < 60 && stp !== 1'b1; i++) cyc(1);
        chk("stp", 16'h0001, 16'(stp));
        chk("exo", 16'h0001, 16'(exo));
        short_detect = 1'b0;
        $display("test short circuit done");
        rst = 1'b1;
        cyc(2);
        {rst, checksum_ok, checksum_done} = 3'b001;
        cyc(1);
        checksum_done = 1'b0;
        chk("ldef", 16'h0001, 16'(ldef));
        chk("nvw", 16'h0001, 16'(nvw));
        chk("blk", 16'h0001, 16'(blk));
        chk("status_word_r", 16'h0001, status_word_r);
        $display("test checksum done");
        tally_and_finish();
    end
endmodule
`default_nettype wire

// ==== dv/asp_ctrl_model.sv ====
// Generator controller model driven by the supervisor's excitation-off output.
// Assumes one system clock; it supplies the measured machine frequency.
`timescale 1ns/1ps
`default_nettype none
module asp_ctrl_model (
    input wire logic clk_sys,
    input wire logic excitation_off_r,
    input wire logic [15:0] run_freq,
    output logic [15:0] freq_meas
);
    initial freq_meas = 16'h0000;
    // Machine is run down to standstill once excitation is removed
    always @(posedge clk_sys) begin
        if (excitation_off_r) begin
            freq_meas <= (freq_meas > 16'h0032) ? freq_meas - 16'h0032 : 16'h0000;
        end else begin
            freq_meas <= run_freq;
        end
    end
endmodule
`default_nettype wire

// ==== rtl/asp_blink.sv ====
// Status LED pattern generator.
// Assumes a one-cycle tick every 100 ms from the supervisor.
`timescale 1ns/1ps
`default_nettype none
module asp_blink (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic tick,
    input wire asp_pkg::asp_led_type pattern,
    output logic led_r
);
    // ----------------------------------------------------------------
    // Pattern selection
    // ----------------------------------------------------------------
    logic [7:0] period_w;
    logic [7:0] on_w;
    logic [7:0] cnt_r;
    logic [7:0] cnt_nxt;
    asp_pkg::asp_led_type pat_r;

    assign period_w = (pattern == asp_pkg::LED_OK) ? asp_pkg::LED_OK_PERIOD :
                      (pattern == asp_pkg::LED_FAULT) ? asp_pkg::LED_FAULT_PERIOD :
                      (pattern == asp_pkg::LED_EXC) ? asp_pkg::LED_EXC_PERIOD :
                      asp_pkg::LED_SPEED_PERIOD;
    assign on_w = (pattern == asp_pkg::LED_OK) ? asp_pkg::LED_OK_ON :
                  (pattern == asp_pkg::LED_FAULT) ? asp_pkg::LED_FAULT_ON :
                  (pattern == asp_pkg::LED_EXC) ? asp_pkg::LED_EXC_ON :
                  asp_pkg::LED_SPEED_ON;
    assign cnt_nxt = (pattern != pat_r) ? 8'h00 :
                     !tick ? cnt_r :
                     (cnt_r >= period_w - 8'h01) ? 8'h00 : cnt_r + 8'h01;

    // ----------------------------------------------------------------
    // Counter and output
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cnt_r <= 8'h00;
            pat_r <= asp_pkg::LED_OK;
            led_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            pat_r <= pattern;
            led_r <= (pattern == asp_pkg::LED_SHORT) || (cnt_nxt < on_w);
        end
    end
endmodule
`default_nettype wire

// ==== rtl/asp_pkg.sv ====
// Constants, field positions and types of the alarm supervisor.
// Assumes a 100 MHz system clock; frequency is measured in 0.1 Hz units.
package asp_pkg;
    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_MHZ = 100;
    localparam int TICK_MS = 100;
    localparam int TICK_CYCLES = TICK_MS * 1000 * CLK_MHZ;
    localparam int TICKS_PER_SEC = 1000 / TICK_MS;
    localparam int LED_OK_PERIOD_S = 2;
    localparam int LED_OK_DUTY_PCT = 50;
    localparam logic [7:0] LED_OK_PERIOD = 8'(LED_OK_PERIOD_S * TICKS_PER_SEC);
    localparam logic [7:0] LED_OK_ON = 8'(LED_OK_PERIOD_S * TICKS_PER_SEC * LED_OK_DUTY_PCT / 100);
    localparam logic [7:0] LED_FAULT_PERIOD = 8'h04;
    localparam logic [7:0] LED_FAULT_ON = 8'h02;
    localparam logic [7:0] LED_EXC_PERIOD = 8'h0A;
    localparam logic [7:0] LED_EXC_ON = 8'h02;
    localparam logic [7:0] LED_SPEED_PERIOD = 8'h0A;
    localparam logic [7:0] LED_SPEED_ON = 8'h08;

    // ----------------------------------------------------------------
    // Parameter locations
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_PROT_CFG = 8'h11;
    localparam logic [7:0] ADDR_USPD_THR = 8'h15;
    localparam logic [7:0] ADDR_SC_TIME = 8'h19;
    localparam logic [7:0] ADDR_OSPD_THR = 8'h1A;
    localparam logic [7:0] ADDR_UEXC_LOW = 8'h1B;
    localparam logic [7:0] ADDR_STATUS = 8'h26;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [15:0] PROT_CFG_RST = 16'h0000;
    localparam logic [15:0] USPD_THR_RST = 16'h0000;
    localparam logic [15:0] SC_TIME_RST = 16'h0000;
    localparam logic [15:0] OSPD_THR_RST = 16'hFFFF;
    localparam logic [15:0] UEXC_LOW_RST = 16'h0000;

    // ----------------------------------------------------------------
    // Fields
    // ----------------------------------------------------------------
    localparam int CFG_DLY_LSB = 12;
    localparam int CFG_MASK_MSB = 7;
    localparam int NUM_ALARMS = 8;
    localparam int AL_CSUM = 0;
    localparam int AL_OV = 1;
    localparam int AL_UV = 2;
    localparam int AL_SC = 3;
    localparam int AL_EXC = 4;
    localparam int AL_USPD = 5;
    localparam int AL_OSPD = 6;
    localparam int AL_UEXC = 7;
    localparam int STAT_ALL_CLEAR = 11;
    localparam logic [7:0] STORED_ALARMS = 8'hDE;

    // ----------------------------------------------------------------
    // Thresholds
    // ----------------------------------------------------------------
    localparam int FREQ_MIN_HZ = 20;
    localparam int FREQ_LSB_PER_HZ = 10;
    localparam logic [15:0] FREQ_MIN = 16'(FREQ_MIN_HZ * FREQ_LSB_PER_HZ);
    localparam int UV_PCT = 5;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        LED_OK,
        LED_FAULT,
        LED_SHORT,
        LED_EXC,
        LED_SPEED
    } asp_led_type;

    typedef enum logic [2:0] {
        ST_INIT = 3'b000,
        ST_RUN = 3'b001,
        ST_STOP = 3'b011,
        ST_BLOCKED = 3'b010,
        ST_SHUTDOWN = 3'b101
    } asp_state_type;
endpackage

// ==== rtl/asp_top.sv ====
// Alarm supervisor with status LED and protective open-collector output.
// Assumes measurements come from logic on clk_sys; the 50/60 jumper is a pin.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - LED blinks 2 s, 50% when healthy
// - Checksum fail: alarm, defaults, write back, block
// - Over-voltage vs ov_threshold input, transient-suppressed
// - Under-voltage below 5%, above underspeed only
// - Short-circuit alarm disabled below 20 Hz
// - Short circuit timeout saves records, stops regulator
// - Zero tolerance time never blocks
// - Stop state removes excitation
// - Underspeed immediate, ramp active, not saved
// - Underspeed threshold from 50/60 and source
// - Overspeed versus parameter 26, recorded only
// - Underexcitation outside window, transient-suppressed
// - Shutdown below 20 Hz until full stop
// - Polarity set: closed normally, opens after delay
// - Polarity clear: open normally, closes after delay
// - Unselected or no alarms keep normal state
// - Config word: mask low, delay top nibble
// - Mask weights 2 to 128 select alarms
// - Status word bits, bit 11 all clear
module asp_top #(
    parameter int TICK_CYCLES = asp_pkg::TICK_CYCLES,
    parameter logic [15:0] UEXC_HIGH = 16'hF000
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic prm_we,
    input wire logic [7:0] prm_addr,
    input wire logic [15:0] prm_wdata,
    output logic [15:0] prm_rdata_r,
    input wire logic checksum_done,
    input wire logic checksum_ok,
    input wire logic transient,
    input wire logic [15:0] freq_meas,
    input wire logic [15:0] vout_meas,
    input wire logic [15:0] vout_nominal,
    input wire logic [15:0] ov_threshold,
    input wire logic exc_overvolt,
    input wire logic short_detect,
    input wire logic exc_overcurrent,
    input wire logic [15:0] exc_observer,
    input wire logic sel_60hz_pin,
    input wire logic freq_sel_sw_mode,
    input wire logic freq_sel_sw_60,
    input wire logic use_param_uspd,
    input wire logic [15:0] trimmer_uspd_thr,
    input wire logic output_polarity_flag,
    output logic protective_alarm_output_r,
    output logic led_r,
    output logic [15:0] status_word_r,
    output logic all_clear_indicator_r,
    output logic load_defaults_r,
    output logic nvm_write_r,
    output logic saved_event_record_r,
    output logic saved_run_time_r,
    output logic regulator_blocked_r,
    output logic stop_indicator_r,
    output logic excitation_off_r,
    output logic current_limit_r,
    output logic vf_ramp_active_r
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    // ----------------------------------------------------------------
    // Tick and pin synchroniser
    // ----------------------------------------------------------------
    logic [31:0] tick_cnt_r;
    logic tick_w;
    logic sel60_meta_r;
    logic sel60_sync_r;

    assign tick_w = (tick_cnt_r == 32'(TICK_CYCLES - 1));

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            tick_cnt_r <= 32'h0000_0000;
            sel60_meta_r <= 1'b0;
            sel60_sync_r <= 1'b0;
        end else begin
            tick_cnt_r <= tick_w ? 32'h0000_0000 : tick_cnt_r + 32'h0000_0001;
            sel60_meta_r <= sel_60hz_pin;
            sel60_sync_r <= sel60_meta_r;
        end
    end

    // ----------------------------------------------------------------
    // Parameter registers
    // ----------------------------------------------------------------
    logic [15:0] cfg_r;
    logic [15:0] uspd_thr_r;
    logic [15:0] sc_time_r;
    logic [15:0] ospd_thr_r;
    logic [15:0] uexc_low_r;
    logic [15:0] rdata_nxt;
    logic load_w;

    assign rdata_nxt = (prm_addr == asp_pkg::ADDR_PROT_CFG) ? cfg_r :
                       (prm_addr == asp_pkg::ADDR_USPD_THR) ? uspd_thr_r :
                       (prm_addr == asp_pkg::ADDR_SC_TIME) ? sc_time_r :
                       (prm_addr == asp_pkg::ADDR_OSPD_THR) ? ospd_thr_r :
                       (prm_addr == asp_pkg::ADDR_UEXC_LOW) ? uexc_low_r :
                       (prm_addr == asp_pkg::ADDR_STATUS) ? status_word_r : 16'h0000;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cfg_r <= asp_pkg::PROT_CFG_RST;
            uspd_thr_r <= asp_pkg::USPD_THR_RST;
            sc_time_r <= asp_pkg::SC_TIME_RST;
            ospd_thr_r <= asp_pkg::OSPD_THR_RST;
            uexc_low_r <= asp_pkg::UEXC_LOW_RST;
        end else if (load_w) begin
            cfg_r <= asp_pkg::PROT_CFG_RST;
            uspd_thr_r <= asp_pkg::USPD_THR_RST;
            sc_time_r <= asp_pkg::SC_TIME_RST;
            ospd_thr_r <= asp_pkg::OSPD_THR_RST;
            uexc_low_r <= asp_pkg::UEXC_LOW_RST;
        end else if (prm_we) begin
            if (prm_addr == asp_pkg::ADDR_PROT_CFG) cfg_r <= prm_wdata;
            if (prm_addr == asp_pkg::ADDR_USPD_THR) uspd_thr_r <= prm_wdata;
            if (prm_addr == asp_pkg::ADDR_SC_TIME) sc_time_r <= prm_wdata;
            if (prm_addr == asp_pkg::ADDR_OSPD_THR) ospd_thr_r <= prm_wdata;
            if (prm_addr == asp_pkg::ADDR_UEXC_LOW) uexc_low_r <= prm_wdata;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            prm_rdata_r <= 16'h0000;
        end else begin
            prm_rdata_r <= rdata_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Alarm conditions
    // ----------------------------------------------------------------
    asp_pkg::asp_state_type state_r;
    asp_pkg::asp_state_type state_nxt;
    logic run_w;
    logic sel60_w;
    logic [15:0] uspd_src_w;
    logic [16:0] uspd_thr_w;
    logic freq_low_w;
    logic below_uspd_w;
    logic [22:0] vout_scaled_w;
    logic [22:0] vnom_scaled_w;
    logic sc_alarm_w;
    logic [7:0] alarm_w;
    logic csum_bad_r;
    logic armed_r;
    logic [7:0] sc_cnt_r;
    logic sc_expire_w;

    assign run_w = (state_r == asp_pkg::ST_RUN);
    assign sel60_w = freq_sel_sw_mode ? freq_sel_sw_60 : sel60_sync_r;
    assign uspd_src_w = use_param_uspd ? uspd_thr_r : trimmer_uspd_thr;
    assign uspd_thr_w = sel60_w ? ({1'b0, uspd_src_w} + 17'({1'b0, uspd_src_w} / 17'h0_0005))
                                : {1'b0, uspd_src_w};
    assign below_uspd_w = ({1'b0, freq_meas} < uspd_thr_w);
    assign freq_low_w = (freq_meas < asp_pkg::FREQ_MIN);
    assign vout_scaled_w = 23'(vout_meas) * 23'h00_0064;
    assign vnom_scaled_w = 23'(vout_nominal) * 23'(100 - asp_pkg::UV_PCT);
    assign sc_alarm_w = run_w && short_detect && !freq_low_w;

    assign alarm_w[asp_pkg::AL_CSUM] = csum_bad_r || load_w;
    assign alarm_w[asp_pkg::AL_OV] = run_w && !transient && (vout_meas > ov_threshold);
    assign alarm_w[asp_pkg::AL_UV] = run_w && !transient && !exc_overvolt && !below_uspd_w
                                     && (vout_scaled_w < vnom_scaled_w);
    assign alarm_w[asp_pkg::AL_SC] = sc_alarm_w || (state_r == asp_pkg::ST_STOP);
    assign alarm_w[asp_pkg::AL_EXC] = run_w && exc_overcurrent;
    assign alarm_w[asp_pkg::AL_USPD] = run_w && below_uspd_w;
    assign alarm_w[asp_pkg::AL_OSPD] = run_w && (freq_meas > ospd_thr_r);
    assign alarm_w[asp_pkg::AL_UEXC] = run_w && !transient
                                       && ((exc_observer > UEXC_HIGH) || (exc_observer < uexc_low_r));

    // Short-circuit tolerance in 100 ms steps
    assign sc_expire_w = sc_alarm_w && (sc_time_r[7:0] != 8'h00) && tick_w
                         && ({1'b0, sc_cnt_r} + 9'h001 >= {1'b0, sc_time_r[7:0]});

    // ----------------------------------------------------------------
    // Supervisor state machine
    // ----------------------------------------------------------------
    assign load_w = (state_r == asp_pkg::ST_INIT) && checksum_done && !checksum_ok;

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            asp_pkg::ST_INIT: begin
                if (checksum_done) begin
                    state_nxt = checksum_ok ? asp_pkg::ST_RUN : asp_pkg::ST_BLOCKED;
                end
            end
            asp_pkg::ST_RUN: begin
                if (sc_expire_w) begin
                    state_nxt = asp_pkg::ST_STOP;
                end else if (armed_r && freq_low_w) begin
                    state_nxt = asp_pkg::ST_SHUTDOWN;
                end
            end
            asp_pkg::ST_SHUTDOWN: begin
                if (freq_meas == 16'h0000) begin
                    state_nxt = asp_pkg::ST_RUN;
                end
            end
            asp_pkg::ST_STOP: state_nxt = asp_pkg::ST_STOP;
            asp_pkg::ST_BLOCKED: state_nxt = asp_pkg::ST_BLOCKED;
            default: state_nxt = asp_pkg::ST_INIT;
        endcase
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_r <= asp_pkg::ST_INIT;
            csum_bad_r <= 1'b0;
            armed_r <= 1'b0;
            sc_cnt_r <= 8'h00;
        end else begin
            state_r <= state_nxt;
            csum_bad_r <= csum_bad_r || load_w;
            armed_r <= (state_nxt == asp_pkg::ST_RUN) && (armed_r || (run_w && !freq_low_w));
            sc_cnt_r <= !sc_alarm_w ? 8'h00 : (tick_w ? sc_cnt_r + 8'h01 : sc_cnt_r);
        end
    end

    // ----------------------------------------------------------------
    // Status, records and control outputs
    // ----------------------------------------------------------------
    logic [7:0] stored_new_w;
    logic stop_entry_w;

    assign stored_new_w = alarm_w & ~status_word_r[7:0] & asp_pkg::STORED_ALARMS;
    assign stop_entry_w = (state_nxt == asp_pkg::ST_STOP) && (state_r != asp_pkg::ST_STOP);

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            status_word_r <= 16'h0800;
            all_clear_indicator_r <= 1'b1;
            load_defaults_r <= 1'b0;
            nvm_write_r <= 1'b0;
            saved_event_record_r <= 1'b0;
            saved_run_time_r <= 1'b0;
            regulator_blocked_r <= 1'b0;
            stop_indicator_r <= 1'b0;
            excitation_off_r <= 1'b0;
            current_limit_r <= 1'b0;
            vf_ramp_active_r <= 1'b0;
        end else begin
            status_word_r <= {4'h0, ~|alarm_w, 3'h0, alarm_w};
            all_clear_indicator_r <= ~|alarm_w;
            load_defaults_r <= load_w;
            nvm_write_r <= load_w;
            saved_event_record_r <= (|stored_new_w) || stop_entry_w;
            saved_run_time_r <= (status_word_r[asp_pkg::STAT_ALL_CLEAR] && |alarm_w) || stop_entry_w;
            regulator_blocked_r <= (state_nxt == asp_pkg::ST_BLOCKED) || (state_nxt == asp_pkg::ST_STOP);
            stop_indicator_r <= (state_nxt == asp_pkg::ST_STOP);
            excitation_off_r <= (state_nxt == asp_pkg::ST_STOP) || (state_nxt == asp_pkg::ST_SHUTDOWN);
            current_limit_r <= alarm_w[asp_pkg::AL_EXC];
            vf_ramp_active_r <= alarm_w[asp_pkg::AL_USPD];
        end
    end

    // ----------------------------------------------------------------
    // Protective output
    // ----------------------------------------------------------------
    logic [7:0] mask_w;
    logic [7:0] dly_ticks_w;
    logic sel_any_w;
    logic [7:0] apo_cnt_r;
    logic apo_act_r;
    logic apo_act_nxt;

    assign mask_w = {cfg_r[asp_pkg::CFG_MASK_MSB:1], 1'b0};
    assign dly_ticks_w = {1'b0, cfg_r[15:asp_pkg::CFG_DLY_LSB], 3'h0}
                         + {3'h0, cfg_r[15:asp_pkg::CFG_DLY_LSB], 1'b0};
    assign sel_any_w = |(alarm_w & mask_w);
    assign apo_act_nxt = sel_any_w && (apo_cnt_r >= dly_ticks_w);

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            apo_cnt_r <= 8'h00;
            apo_act_r <= 1'b0;
            protective_alarm_output_r <= 1'b0;
        end else begin
            apo_cnt_r <= !sel_any_w ? 8'h00 :
                         (tick_w && !apo_act_nxt) ? apo_cnt_r + 8'h01 : apo_cnt_r;
            apo_act_r <= apo_act_nxt;
            protective_alarm_output_r <= output_polarity_flag ^ apo_act_r;
        end
    end

    // ----------------------------------------------------------------
    // LED pattern
    // ----------------------------------------------------------------
    asp_pkg::asp_led_type pattern_w;

    assign pattern_w = (csum_bad_r || !run_w) ? asp_pkg::LED_FAULT :
                       alarm_w[asp_pkg::AL_SC] ? asp_pkg::LED_SHORT :
                       alarm_w[asp_pkg::AL_EXC] ? asp_pkg::LED_EXC :
                       (alarm_w[asp_pkg::AL_USPD] || alarm_w[asp_pkg::AL_OSPD]) ? asp_pkg::LED_SPEED :
                       asp_pkg::LED_OK;

    asp_blink u_blink (
        .clk_sys(clk_sys),
        .rst(rst),
        .tick(tick_w),
        .pattern(pattern_w),
        .led_r(led_r)
    );

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    sequence s_quiet;
        !sel_any_w ##1 (!sel_any_w && $stable(output_polarity_flag));
    endsequence

    AST_ALL_CLEAR: assert property (status_word_r[11] == ~|status_word_r[7:0])
        else $error("all-clear bit disagrees with alarm bits");
    AST_CSUM_BLOCK: assert property (load_w |=> load_defaults_r && nvm_write_r
        && regulator_blocked_r && status_word_r[0])
        else $error("checksum failure not handled");
    AST_SC_LOWFREQ: assert property (freq_low_w && state_r != asp_pkg::ST_STOP
        |=> !status_word_r[3])
        else $error("short-circuit alarm below minimum frequency");
    AST_SC_ZERO: assert property (state_r == asp_pkg::ST_RUN && sc_time_r == 16'h0000
        |=> state_r != asp_pkg::ST_STOP)
        else $error("stop entered with zero tolerance time");
    AST_STOP_EXC: assert property ($rose(state_r == asp_pkg::ST_STOP)
        |-> excitation_off_r && stop_indicator_r && saved_run_time_r)
        else $error("stop without excitation removal");
    AST_APO_NORMAL: assert property (s_quiet |=> protective_alarm_output_r == $past(output_polarity_flag))
        else $error("protective output not normal without selected alarm");
    AST_APO_NODELAY: assert property ((sel_any_w && dly_ticks_w == 8'h00
        && $stable(output_polarity_flag)) [*2] |=> protective_alarm_output_r != $past(output_polarity_flag))
        else $error("protective output not switched with zero delay");
    AST_USPD_RAMP: assert property (run_w && below_uspd_w |=> vf_ramp_active_r
        && (!saved_event_record_r || $past(|stored_new_w) || $past(stop_entry_w)))
        else $error("underspeed did not raise ramp");
endmodule
`default_nettype wire
